// ---- shared/brch_map.svh ----
// Character codes, error codes and field limits of the bit relay command handler.
// Included by the handler module, the port checker and the host model; holds definitions only.
`ifndef BRCH_MAP_SVH
`define BRCH_MAP_SVH

`define BRCH_STX        8'h02
`define BRCH_ETX        8'h03
`define BRCH_CR         8'h0D
`define BRCH_CH_0       8'h30
`define BRCH_CH_1       8'h31
`define BRCH_CH_I       8'h49
`define BRCH_CH_E       8'h45
`define BRCH_CH_R       8'h52
`define BRCH_CH_O       8'h4F
`define BRCH_CH_K       8'h4B
`define BRCH_COMMA      8'h2C
`define BRCH_SPACE      8'h20

`define BRCH_CODE_CRD   24'h42_5244
`define BRCH_CODE_CWR   24'h42_5752
`define BRCH_CODE_RRD   24'h42_5252
`define BRCH_CODE_RWR   24'h42_5257
`define BRCH_CODE_MSET  24'h42_5253
`define BRCH_CODE_MRD   24'h42_524D

`define BRCH_ERR_NONE   8'h00
`define BRCH_ERR_REG    8'h03
`define BRCH_ERR_SET    8'h04
`define BRCH_ERR_CNT    8'h05
`define BRCH_ERR_MON    8'h06
`define BRCH_ERR_PARM   8'h08
`define BRCH_ERR_SUM    8'h42

`define BRCH_CONT_MAX   14'h0100
`define BRCH_RAND_MAX   14'h0020
`define BRCH_HDR_LAST   9'h007
`define BRCH_RELAY_LAST 9'h004
`define BRCH_CONT_CLAST 9'h002
`define BRCH_RAND_CLAST 9'h001
`define BRCH_ER_LAST    9'h008

`endif

// ---- shared/brch_pkg.sv ----
// Types of the bit relay command handler: parser and sender phases, commands, state.
// Needs no other file.
package brch_pkg;

   typedef enum logic [3:0] {
      P_IDLE  = 4'h0,
      P_HDR   = 4'h1,
      P_RELAY = 4'h2,
      P_SEP   = 4'h3,
      P_CNT   = 4'h4,
      P_DATA  = 4'h5,
      P_SUM   = 4'h6,
      P_ETX   = 4'h7,
      P_CR    = 4'h8,
      P_SKIP  = 4'h9
   } brch_rx_t;

   typedef enum logic [2:0] {
      C_NONE = 3'h0,
      C_CRD  = 3'h1,
      C_CWR  = 3'h2,
      C_RRD  = 3'h3,
      C_RWR  = 3'h4,
      C_MSET = 3'h5,
      C_MRD  = 3'h6
   } brch_cmd_t;

   typedef enum logic [3:0] {
      T_IDLE = 4'h0,
      T_STX  = 4'h1,
      T_HDR  = 4'h2,
      T_OK   = 4'h3,
      T_DATA = 4'h4,
      T_ER   = 4'h5,
      T_SUM  = 4'h6,
      T_ETX  = 4'h7,
      T_CR   = 4'h8
   } brch_tx_t;

   typedef struct packed {
      brch_rx_t         rph;
      brch_rx_t         ret;
      brch_cmd_t        cmd;
      logic             addr_ok;
      logic [8:0]       fcnt;
      logic [13:0]      num;
      logic [8:0]       cnt;
      logic [5:0]       item;
      logic [7:0]       start;
      logic [7:0]       sum;
      logic [7:0]       rsum;
      logic [23:0]      cmd_chr;
      logic [7:0]       err;
      logic [7:0]       err_par;
      logic [255:0]     wdata;
      logic [255:0]     wmask;
      logic [31:0][7:0] lst;
      logic [31:0][7:0] mon;
      logic [5:0]       mon_cnt;
      logic [255:0]     relay;
      brch_tx_t         tph;
      logic [8:0]       tcnt;
      logic [7:0]       tsum;
      logic [7:0]       tx_data;
      logic             tx_valid;
   } brch_state_t;

endpackage

// ---- hdl/brch_handler.sv ----
// Bit relay command handler: parses framed ASCII commands, updates and reports relays.
// Assumes a byte stream with valid/ready on both sides, synchronous to CLK_SYS_IN.
`timescale 1ns/1ps
`include "brch_map.svh"

module brch_handler
(
   input  wire logic         CLK_SYS_IN,
   input  wire logic         RST_B_IN,
   input  wire logic [15:0]  STATION_ADDR_IN,
   input  wire logic         CHECKSUM_EN_IN,
   input  wire logic         RX_VALID_IN,
   input  wire logic [7:0]   RX_DATA_IN,
   output logic              RX_READY_OUT,
   output logic              TX_VALID_OUT,
   output logic [7:0]        TX_DATA_OUT,
   input  wire logic         TX_READY_IN,
   output logic [255:0]      RELAY_STATE_OUT
);

////////////////////////////////////////////////////////////////////////////////
   brch_pkg::brch_state_t r;
   brch_pkg::brch_state_t next_r;
   brch_pkg::brch_rx_t    end_ph;
   logic                  take;
   logic [7:0]            b;
   logic                  dig;
   logic [13:0]           v;
   logic [4:0]            hx;
   logic                  is_cont;
   logic                  item_last;
   logic                  fail;
   logic [7:0]            fcode;
   logic [7:0]            fpar;
   logic                  done;
   logic [7:0]            pos;
   logic [7:0]            ch;
   logic                  dbit;
   logic [8:0]            n_rd;
   logic                  has_data;
   brch_pkg::brch_tx_t    tend;

   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39)
         return {1'b1, c[3:0]};
      if (c >= 8'h41 && c <= 8'h46)
         return {1'b1, 4'(c[3:0] + 4'h9)};
      return 5'h00;
   endfunction

   function automatic logic [7:0] to_hex(input logic [3:0] x);
      return (x < 4'hA) ? 8'(8'h30 + {4'h0, x}) : 8'(8'h37 + {4'h0, x});
   endfunction

   // Receiving stalls while an answer goes out; one frame at a time
   assign RX_READY_OUT    = (r.tph == brch_pkg::T_IDLE);
   assign TX_VALID_OUT    = r.tx_valid;
   assign TX_DATA_OUT     = r.tx_data;
   assign RELAY_STATE_OUT = r.relay;

   assign take      = RX_VALID_IN && RX_READY_OUT;
   assign b         = RX_DATA_IN;
   assign dig       = (b >= `BRCH_CH_0) && (b <= 8'h39);
   assign v         = 14'(r.num * 14'h000A) + {10'h000, b[3:0]};
   assign hx        = hex_val(b);
   assign end_ph    = CHECKSUM_EN_IN ? brch_pkg::P_SUM : brch_pkg::P_ETX;
   assign is_cont   = (r.cmd == brch_pkg::C_CRD) || (r.cmd == brch_pkg::C_CWR);
   assign item_last = (9'({3'h0, r.item} + 9'h001) == r.cnt);
   assign has_data  = (r.cmd == brch_pkg::C_CRD) || (r.cmd == brch_pkg::C_RRD)
                      || (r.cmd == brch_pkg::C_MRD);
   assign n_rd      = (r.cmd == brch_pkg::C_MRD) ? {3'h0, r.mon_cnt} : r.cnt;
   assign tend      = CHECKSUM_EN_IN ? brch_pkg::T_SUM : brch_pkg::T_ETX;

////////////////////////////////////////////////////////////////////////////////
   // Relay position of the value being received
   always_comb
   begin
      if (is_cont)
         pos = 8'(r.start + r.fcnt[7:0]);
      else
         pos = r.lst[r.item[4:0]];
   end

   // Relay state sent as the next data character
   always_comb
   begin
      if (r.cmd == brch_pkg::C_CRD)
         dbit = r.relay[8'(r.start + r.tcnt[7:0])];
      else if (r.cmd == brch_pkg::C_RRD)
         dbit = r.relay[r.lst[r.tcnt[4:0]]];
      else
         dbit = r.relay[r.mon[r.tcnt[4:0]]];
   end

////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_r = r;
      fail   = 1'b0;
      fcode  = `BRCH_ERR_NONE;
      fpar   = 8'h00;
      done   = 1'b0;
      ch     = 8'h00;
      if (take)
      begin
         if (b == `BRCH_STX)
         begin
            next_r.rph     = brch_pkg::P_HDR;
            next_r.fcnt    = 9'h000;
            next_r.sum     = 8'h00;
            next_r.err     = `BRCH_ERR_NONE;
            next_r.err_par = 8'h00;
            next_r.wmask   = '0;
            next_r.num     = 14'h0000;
            next_r.item    = 6'h00;
            next_r.cmd     = brch_pkg::C_NONE;
            next_r.addr_ok = 1'b0;
         end
         else
         begin
            if (r.rph inside {brch_pkg::P_HDR, brch_pkg::P_RELAY, brch_pkg::P_SEP,
                              brch_pkg::P_CNT, brch_pkg::P_DATA})
               next_r.sum = r.sum + b;
            next_r.fcnt = r.fcnt + 9'h001;
            unique case (r.rph)
               brch_pkg::P_IDLE:
                  next_r.fcnt = r.fcnt;
               brch_pkg::P_HDR:
               begin
                  if (r.fcnt == 9'h000)
                     next_r.addr_ok = (b == STATION_ADDR_IN[15:8]);
                  else if (r.fcnt == 9'h001)
                     next_r.addr_ok = r.addr_ok && (b == STATION_ADDR_IN[7:0]);
                  else if ((r.fcnt == 9'h002 && b != `BRCH_CH_0)
                           || (r.fcnt == 9'h003 && b != `BRCH_CH_1)
                           || (r.fcnt == 9'h004 && b != `BRCH_CH_0))
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_PARM;
                  end
                  else if (r.fcnt >= 9'h005)
                     next_r.cmd_chr = {r.cmd_chr[15:0], b};
                  if (r.fcnt == `BRCH_HDR_LAST)
                  begin
                     next_r.fcnt = 9'h000;
                     next_r.num  = 14'h0000;
                     next_r.rph  = brch_pkg::P_CNT;
                     case ({r.cmd_chr[15:0], b})
                        `BRCH_CODE_CRD:
                        begin
                           next_r.cmd = brch_pkg::C_CRD;
                           next_r.rph = brch_pkg::P_RELAY;
                        end
                        `BRCH_CODE_CWR:
                        begin
                           next_r.cmd = brch_pkg::C_CWR;
                           next_r.rph = brch_pkg::P_RELAY;
                        end
                        `BRCH_CODE_RRD:  next_r.cmd = brch_pkg::C_RRD;
                        `BRCH_CODE_RWR:  next_r.cmd = brch_pkg::C_RWR;
                        `BRCH_CODE_MSET: next_r.cmd = brch_pkg::C_MSET;
                        `BRCH_CODE_MRD:
                        begin
                           next_r.cmd = brch_pkg::C_MRD;
                           next_r.rph = end_ph;
                        end
                        default:
                        begin
                           fail  = 1'b1;
                           fcode = `BRCH_ERR_PARM;
                        end
                     endcase
                  end
               end
               brch_pkg::P_RELAY:
               begin
                  fpar = 8'({2'h0, r.item} + 8'h01);
                  if ((r.fcnt == 9'h000) ? (b != `BRCH_CH_I) : !dig)
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_REG;
                  end
                  else if (r.fcnt != 9'h000)
                     next_r.num = v;
                  if (!fail && r.fcnt == `BRCH_RELAY_LAST)
                  begin
                     next_r.fcnt = 9'h000;
                     next_r.num  = 14'h0000;
                     if (v == 14'h0000 || v > `BRCH_CONT_MAX)
                     begin
                        fail  = 1'b1;
                        fcode = `BRCH_ERR_REG;
                     end
                     else if (is_cont)
                     begin
                        next_r.start = 8'(v - 14'h0001);
                        next_r.rph   = brch_pkg::P_SEP;
                        next_r.ret   = brch_pkg::P_CNT;
                     end
                     else
                     begin
                        next_r.lst[r.item[4:0]] = 8'(v - 14'h0001);
                        next_r.rph = brch_pkg::P_SEP;
                        next_r.ret = brch_pkg::P_DATA;
                        if (r.cmd != brch_pkg::C_RWR)
                        begin
                           next_r.item = 6'(r.item + 6'h01);
                           next_r.ret  = brch_pkg::P_RELAY;
                           if (item_last)
                              next_r.rph = end_ph;
                        end
                     end
                  end
               end
               brch_pkg::P_SEP:
               begin
                  if (b == `BRCH_COMMA || b == `BRCH_SPACE)
                  begin
                     next_r.rph  = r.ret;
                     next_r.fcnt = 9'h000;
                  end
                  else
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_PARM;
                  end
               end
               brch_pkg::P_CNT:
               begin
                  if (!dig)
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_CNT;
                  end
                  else
                     next_r.num = v;
                  if (!fail && r.fcnt == (is_cont ? `BRCH_CONT_CLAST : `BRCH_RAND_CLAST))
                  begin
                     next_r.fcnt = 9'h000;
                     next_r.num  = 14'h0000;
                     next_r.cnt  = 9'(v);
                     next_r.item = 6'h00;
                     if (v == 14'h0000 || v > (is_cont ? `BRCH_CONT_MAX : `BRCH_RAND_MAX))
                     begin
                        fail  = 1'b1;
                        fcode = `BRCH_ERR_CNT;
                     end
                     else if (is_cont && (14'(r.start) + v) > `BRCH_CONT_MAX)
                     begin
                        fail  = 1'b1;
                        fcode = `BRCH_ERR_SET;
                     end
                     else if (r.cmd == brch_pkg::C_CRD)
                        next_r.rph = end_ph;
                     else if (r.cmd == brch_pkg::C_CWR)
                     begin
                        next_r.rph = brch_pkg::P_SEP;
                        next_r.ret = brch_pkg::P_DATA;
                     end
                     else
                        next_r.rph = brch_pkg::P_RELAY;
                  end
               end
               brch_pkg::P_DATA:
               begin
                  if (b != `BRCH_CH_0 && b != `BRCH_CH_1)
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_SET;
                     fpar  = is_cont ? 8'(r.fcnt + 9'h001) : 8'({2'h0, r.item} + 8'h01);
                  end
                  else
                  begin
                     next_r.wdata[pos] = b[0];
                     next_r.wmask[pos] = 1'b1;
                     if (is_cont)
                     begin
                        if (9'(r.fcnt + 9'h001) == r.cnt)
                        begin
                           // Checksum field counts its own two characters from zero
                           next_r.fcnt = 9'h000;
                           next_r.rph  = end_ph;
                        end
                     end
                     else
                     begin
                        next_r.fcnt = 9'h000;
                        next_r.item = 6'(r.item + 6'h01);
                        next_r.rph  = item_last ? end_ph : brch_pkg::P_SEP;
                        next_r.ret  = brch_pkg::P_RELAY;
                     end
                  end
               end
               brch_pkg::P_SUM:
               begin
                  next_r.rsum = {r.rsum[3:0], hx[3:0]};
                  if (!hx[4])
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_PARM;
                  end
                  else if (r.fcnt == 9'h001)
                  begin
                     if ({r.rsum[3:0], hx[3:0]} != r.sum)
                     begin
                        fail  = 1'b1;
                        fcode = `BRCH_ERR_SUM;
                     end
                     else
                        next_r.rph = brch_pkg::P_ETX;
                  end
               end
               brch_pkg::P_ETX:
               begin
                  if (b == `BRCH_ETX)
                     next_r.rph = brch_pkg::P_CR;
                  else
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_PARM;
                  end
               end
               brch_pkg::P_CR:
               begin
                  if (b == `BRCH_CR)
                     done = 1'b1;
                  else
                  begin
                     fail  = 1'b1;
                     fcode = `BRCH_ERR_PARM;
                  end
               end
               brch_pkg::P_SKIP:
                  done = (b == `BRCH_CR);
            endcase
         end
      end
      // First fault wins; the rest of the frame is drained up to CR
      if (fail)
      begin
         next_r.err     = fcode;
         next_r.err_par = fpar;
         next_r.rph     = brch_pkg::P_SKIP;
      end
      // Frames for another station are consumed silently
      if (done)
      begin
         next_r.rph = brch_pkg::P_IDLE;
         if (r.addr_ok)
         begin
            next_r.tph  = brch_pkg::T_STX;
            next_r.tcnt = 9'h000;
            if (r.err == `BRCH_ERR_NONE && r.cmd == brch_pkg::C_MRD && r.mon_cnt == 6'h00)
               next_r.err = `BRCH_ERR_MON;
            else if (r.err == `BRCH_ERR_NONE)
            begin
               // Writes commit only after the whole frame checked out
               next_r.relay = (r.relay & ~r.wmask) | (r.wdata & r.wmask);
               if (r.cmd == brch_pkg::C_MSET)
               begin
                  next_r.mon     = r.lst;
                  next_r.mon_cnt = r.cnt[5:0];
               end
            end
         end
      end
      // Answer sender
      unique case (r.tph)
         brch_pkg::T_IDLE: ch = 8'h00;
         brch_pkg::T_STX:  ch = `BRCH_STX;
         brch_pkg::T_HDR:
            ch = (r.tcnt == 9'h000) ? STATION_ADDR_IN[15:8] :
                 (r.tcnt == 9'h001) ? STATION_ADDR_IN[7:0] :
                 (r.tcnt == 9'h002) ? `BRCH_CH_0 : `BRCH_CH_1;
         brch_pkg::T_OK:   ch = (r.tcnt == 9'h000) ? `BRCH_CH_O : `BRCH_CH_K;
         brch_pkg::T_DATA: ch = dbit ? `BRCH_CH_1 : `BRCH_CH_0;
         brch_pkg::T_ER:
            unique case (r.tcnt[3:0])
               4'h0:    ch = `BRCH_CH_E;
               4'h1:    ch = `BRCH_CH_R;
               4'h2:    ch = to_hex(r.err[7:4]);
               4'h3:    ch = to_hex(r.err[3:0]);
               4'h4:    ch = to_hex(r.err_par[7:4]);
               4'h5:    ch = to_hex(r.err_par[3:0]);
               4'h6:    ch = r.cmd_chr[23:16];
               4'h7:    ch = r.cmd_chr[15:8];
               default: ch = r.cmd_chr[7:0];
            endcase
         brch_pkg::T_SUM:
            ch = (r.tcnt == 9'h000) ? to_hex(r.tsum[7:4]) : to_hex(r.tsum[3:0]);
         brch_pkg::T_ETX:  ch = `BRCH_ETX;
         brch_pkg::T_CR:   ch = `BRCH_CR;
      endcase
      if (r.tph != brch_pkg::T_IDLE && (!r.tx_valid || TX_READY_IN))
      begin
         next_r.tx_valid = 1'b1;
         next_r.tx_data  = ch;
         next_r.tcnt     = r.tcnt + 9'h001;
         // Own hex digits stay out of the sum being sent
         if (r.tph != brch_pkg::T_SUM)
            next_r.tsum = r.tsum + ch;
         unique case (r.tph)
            brch_pkg::T_IDLE: next_r.tph = brch_pkg::T_IDLE;
            brch_pkg::T_STX:
            begin
               next_r.tph  = brch_pkg::T_HDR;
               next_r.tcnt = 9'h000;
               next_r.tsum = 8'h00;
            end
            brch_pkg::T_HDR:
               if (r.tcnt == 9'h003)
               begin
                  next_r.tcnt = 9'h000;
                  next_r.tph  = (r.err != `BRCH_ERR_NONE) ? brch_pkg::T_ER : brch_pkg::T_OK;
               end
            brch_pkg::T_OK:
               if (r.tcnt == 9'h001)
               begin
                  next_r.tcnt = 9'h000;
                  next_r.tph  = has_data ? brch_pkg::T_DATA : tend;
               end
            brch_pkg::T_DATA:
               if (9'(r.tcnt + 9'h001) == n_rd)
               begin
                  next_r.tcnt = 9'h000;
                  next_r.tph  = tend;
               end
            brch_pkg::T_ER:
               if (r.tcnt == `BRCH_ER_LAST)
               begin
                  next_r.tcnt = 9'h000;
                  next_r.tph  = tend;
               end
            brch_pkg::T_SUM:
               if (r.tcnt == 9'h001)
                  next_r.tph = brch_pkg::T_ETX;
            brch_pkg::T_ETX: next_r.tph = brch_pkg::T_CR;
            brch_pkg::T_CR:  next_r.tph = brch_pkg::T_IDLE;
         endcase
      end
      else if (TX_READY_IN)
         next_r.tx_valid = 1'b0;
   end

////////////////////////////////////////////////////////////////////////////////
   // Reset empties the monitor list and turns all relays off
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
         r <= '0;
      else
         r <= next_r;
   end

endmodule

// ---- verification/brch_props.sv ----
// Port checker of the bit relay command handler.
// Bound below to every brch_handler; sees its ports only.
`timescale 1ns/1ps
`include "brch_map.svh"
module brch_props
(
   input wire logic         CLK_SYS_IN,
   input wire logic         RST_B_IN,
   input wire logic [15:0]  STATION_ADDR_IN,
   input wire logic         RX_VALID_IN,
   input wire logic [7:0]   RX_DATA_IN,
   input wire logic         RX_READY_OUT,
   input wire logic         TX_VALID_OUT,
   input wire logic [7:0]   TX_DATA_OUT,
   input wire logic         TX_READY_IN,
   input wire logic [255:0] RELAY_STATE_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   ////////////////////////////////////////////////////////////
   AST_TX_HOLD: assert property (TX_VALID_OUT && !TX_READY_IN |=>
      TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("answer byte not held");
   AST_RX_BLOCK: assert property (TX_VALID_OUT && TX_DATA_OUT != `BRCH_CR |->
      !RX_READY_OUT) else $error("intake open while answering");
   AST_FIRST_STX: assert property ($rose(TX_VALID_OUT) |->
      TX_DATA_OUT == `BRCH_STX) else $error("answer not opened by STX");
   AST_ADDR_NEXT: assert property (TX_VALID_OUT && TX_READY_IN && TX_DATA_OUT == `BRCH_STX
      |=> TX_VALID_OUT && TX_DATA_OUT == STATION_ADDR_IN[15:8]) else $error("address not after STX");
   AST_ETX_CR: assert property (TX_VALID_OUT && TX_READY_IN && TX_DATA_OUT == `BRCH_ETX
      |=> TX_VALID_OUT && TX_DATA_OUT == `BRCH_CR) else $error("CR not after ETX");
   AST_CR_END: assert property (TX_VALID_OUT && TX_READY_IN && TX_DATA_OUT == `BRCH_CR
      |=> !TX_VALID_OUT) else $error("bytes after answer CR");
   // Relays move only at a frame's CR, never while answering
   AST_RELAY_QUIET: assert property (TX_VALID_OUT |=>
      $stable(RELAY_STATE_OUT)) else $error("relays moved while answering");
   AST_RELAY_SRC: assert property ($changed(RELAY_STATE_OUT) |->
      $past(RX_VALID_IN && RX_READY_OUT && RX_DATA_IN == `BRCH_CR)) else $error("relay change without CR");
endmodule
bind brch_handler brch_props i_brch_props (.CLK_SYS_IN, .RST_B_IN, .STATION_ADDR_IN,
   .RX_VALID_IN, .RX_DATA_IN, .RX_READY_OUT, .TX_VALID_OUT, .TX_DATA_OUT, .TX_READY_IN,
   .RELAY_STATE_OUT);

// ---- verification/brch_host.sv ----
// Host model: frames commands, collects answers.
// Tasks are called from the bench; one clock.
`timescale 1ns/1ps
`include "brch_map.svh"
module brch_host
(
   input  wire logic       clk,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            tx_ready
);
   logic slow;
   initial
   begin
      slow = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   task automatic send(input string s, input logic cs);
      logic [7:0] q[$];
      logic [7:0] sum;
      logic       ok;
      sum = 8'h00;
      foreach (s[i])
      begin
         q.push_back(s[i]);
         sum += s[i];
      end
      if (cs)
         q = {q, hx(sum[7:4]), hx(sum[3:0])};
      q = {`BRCH_STX, q, `BRCH_ETX, `BRCH_CR};
      foreach (q[i])
      begin
         rx_valid = 1'b1;
         rx_data = q[i];
         do
         begin
            ok = rx_ready;
            @(posedge clk);
            #1;
         end
         while (!ok);
      end
      rx_valid = 1'b0;
      rx_data = ~rx_data; // Released line shows no stale byte
   endtask
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction
   // Slow mode takes every other cycle, so bytes must be held
   task automatic recv(output string r);
      logic [7:0] d;
      logic       got;
      r = "";
      for (int n = 0; n < 3000; n++)
      begin
         tx_ready = !slow || n[0];
         got = tx_valid && tx_ready;
         d = tx_data;
         @(posedge clk);
         #1;
         if (got && d == `BRCH_CR)
            break;
         if (got && d != `BRCH_STX && d != `BRCH_ETX)
            r = $sformatf("%s%c", r, d);
      end
      tx_ready = 1'b0;
   endtask
endmodule

// ---- verification/bit_relay_command_handler_test.sv ----
// Self-checking bench of the bit relay command handler.
// Needs brch_handler, brch_host and the bound checker.
`timescale 1ns/1ps
module bit_relay_command_handler_test;
   logic         clk;
   logic         rst_b;
   logic         cs;
   logic         rx_valid;
   logic [7:0]   rx_data;
   logic         rx_ready;
   logic         tx_valid;
   logic [7:0]   tx_data;
   logic         tx_ready;
   logic [255:0] relay;
   int           num_errors = 0;
   int           cmp_count = 0;
   brch_handler i_brch_handler (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .STATION_ADDR_IN(16'h3031),
      .CHECKSUM_EN_IN(cs), .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data), .RX_READY_OUT(rx_ready),
      .TX_VALID_OUT(tx_valid), .TX_DATA_OUT(tx_data), .TX_READY_IN(tx_ready), .RELAY_STATE_OUT(relay));
   brch_host i_brch_host (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
   ////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_str(input string what, input string exp, input string got);
      cmp_count++;
      if (exp != got)
      begin
         num_errors++;
         $display("unexpected %s: expected %s, seen %s", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (exp !== got)
      begin
         num_errors++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   // Error answers are judged up to the first code only
   task automatic xact(input string cmd, input string exp);
      string r;
      i_brch_host.send(cmd, cs);
      i_brch_host.recv(r);
      if (exp.substr(4, 5) == "ER")
         r = r.substr(0, 7);
      cmp_str(cmd, exp, r);
   endtask
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_b = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_cont();
      string r;
      cs = 1'b1;
      i_brch_host.slow = 1'b1;
      xact("01010BWRI0033,001,1", "0101OK5C");
      i_brch_host.send("01010BRDI0033,00100", 1'b0);
      i_brch_host.recv(r);
      cmp_str("bad sum", "0101ER42", r.substr(0, 7));
      cmp_bit("relay 33", 1'b1, relay[32]);
      cs = 1'b0;
      i_brch_host.slow = 1'b0;
      xact("01010BRDI0032,003", "0101OK010");
      xact({"01010BWRI0001,256,", {256{"1"}}}, "0101OK");
      cmp_bit("all relays", 1'b1, &relay);
      xact("01010BWRI0256,002,11", "0101ER04");
      xact("01010BWRI0001,257,1", "0101ER05");
      xact("01010BWRI0040,002,02", "0101ER04");
      cmp_bit("relay 40", 1'b1, relay[39]);
   endtask
   task automatic t_rand();
      xact("01010BRW02I0001,0,I0002,1", "0101OK");
      xact("01010BRR03I0002,I0001,I0003", "0101OK101");
      xact("01010BRW01I0005,7", "0101ER04");
      xact("01010BRR33I0001", "0101ER05");
      xact("01010BRR01D0001", "0101ER03");
      xact("02010BRW01I0005,0", "");
      cmp_bit("relay 5", 1'b1, relay[4]);
   endtask
   task automatic t_mon();
      xact("01010BRS02I0002,I0001", "0101OK");
      xact("01010BRM", "0101OK10");
      xact("01010BRM", "0101OK10");
      do_reset();
      xact("01010BRM", "0101ER06");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Longest run is a few thousand cycles
   initial
   begin
      #1_000_000;
      num_errors++;
      end_sim();
   end
   initial
   begin
      cs = 1'b0;
      do_reset();
      t_cont();
      t_rand();
      t_mon();
      end_sim();
   end
endmodule
